// File: hw/drive_words_pkg.sv
// Constants for the drive command/status word interpreter.
// Assumes a single 100 MHz clock domain and a simple strobe register port.
package drive_words_pkg;

	// Register offsets on the simple register port (word addresses).
	localparam logic [3:0] ADDR_CMD       = 4'h0;
	localparam logic [3:0] ADDR_REF       = 4'h1;
	localparam logic [3:0] ADDR_STATUS    = 4'h2;
	localparam logic [3:0] ADDR_OUTFREQ   = 4'h3;
	localparam logic [3:0] ADDR_CONFIG    = 4'h4;
	localparam logic [3:0] ADDR_ACTIVE    = 4'h5;
	localparam logic [3:0] ADDR_TRIPCNT   = 4'h6;

	// Command word bit positions.
	localparam int CMD_PRESET_LO  = 0;
	localparam int CMD_PRESET_HI  = 1;
	localparam int CMD_DC_BRAKE_N = 2;
	localparam int CMD_COAST_N    = 3;
	localparam int CMD_QSTOP_N    = 4;
	localparam int CMD_FREEZE_N   = 5;
	localparam int CMD_START      = 6;
	localparam int CMD_RESET      = 7;
	localparam int CMD_JOG        = 8;
	localparam int CMD_VALID      = 10;
	localparam int CMD_RELAY1     = 11;
	localparam int CMD_RELAY2     = 12;
	localparam int CMD_SETUP_LO   = 13;
	localparam int CMD_SETUP_HI   = 14;
	localparam int CMD_REVERSE    = 15;

	// Status word bit positions.
	localparam int ST_SERIAL   = 9;
	localparam int ST_IN_RANGE = 10;
	localparam int ST_RUNNING  = 11;
	localparam int ST_VOLT     = 13;
	localparam int ST_CURRENT  = 14;
	localparam int ST_THERMAL  = 15;

	// Configuration register bit positions.
	localparam int CFG_LOCAL      = 0;
	localparam int CFG_RELAY1_BUS = 1;
	localparam int CFG_RELAY2_BUS = 2;
	localparam int CFG_MULTISETUP = 3;
	localparam int CFG_REV_BUS    = 4;

	// Reset values and scaling.
	localparam logic [15:0] CMD_RESET_VAL  = 16'h0000;
	localparam logic [15:0] REF_RESET_VAL  = 16'h0000;
	localparam logic [7:0]  CFG_RESET_VAL  = 8'h00;
	localparam logic [15:0] FULL_SCALE     = 16'h4000;
	localparam int          SCALE_SHIFT    = 14;

	typedef enum logic [1:0] {
		STOP_NONE,
		STOP_COAST,
		STOP_DCBRAKE,
		STOP_RAMP
	} stop_kind_e;

endpackage

// File: hw/drive_control_status_words.sv
// Command word and status word interpreter of a drive's fieldbus process data.
// Assumes telegram framing, motor control and parameter storage live outside;
// motor-side conditions and the panel key arrive as synchronous levels on mclk,
// while the start and reversing terminals are raw pins and are synchronised here.
//
// Summary of operation
// RULE_01: Status bit 9 clear and control refused when panel stop or local mode.
// RULE_02: Status bit 10 set while output frequency lies strictly within limits.
// RULE_03: Status bit 11 set on start command or nonzero output frequency.
// RULE_04: Status bit 13 set on DC bus undervoltage or overvoltage.
// RULE_05: Status bit 14 set above current limit; trip after configured delay.
// RULE_06: Status bit 15 set on motor, converter or thermistor overtemperature.
// RULE_07: Reference is signed 16 bits, 16384 equals 100 percent.
// RULE_08: Reference 0 to 16384 maps linearly from minimum to maximum reference.
// RULE_09: A negative reference reverses direction of rotation.
// RULE_10: Output frequency reported as signed 16 bits scaled across limit span.
// RULE_11: Command bits 1 and 0 select one of four preset references.
// RULE_12: Command bit 2 low requests DC braking stop.
// RULE_13: Command bit 3 low switches output stage off at once.
// RULE_14: Command bit 4 low requests quick stop with ramp-down; the code blocks quick_stop_req while frozen.
// RULE_15: Command bit 5 low freezes present output frequency.
// RULE_16: During freeze, ramp stop and start terminal are ignored.
// RULE_17: Command bit 6 high permits start; low requests ramp stop.
// RULE_18: Trip reset only on rising edge of command bit 7.
// RULE_19: Command bit 8 high selects jog frequency.
// RULE_20: Command bit 9 has no effect.
// RULE_21: Command word ignored when its bit 10 is low.
// RULE_22: Bits 11 and 12 drive relays only when configured for bus control.
// RULE_23: Bits 14 and 13 select setup only when multi-setup configured.
// RULE_24: Bit 15 reverses only when reversing source includes the bus.
// RULE_25: Command and reference latch together per valid telegram.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps

module drive_control_status_words
	import drive_words_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rst,
	// Register port.
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Telegram delivery from the link framer.
	input  wire logic        tel_valid,
	input  wire logic [15:0] tel_cmd,
	input  wire logic [15:0] tel_ref,
	// Drive-side conditions.
	input  wire logic        panel_stop_key,
	input  wire logic [15:0] out_freq_hz,
	input  wire logic [15:0] freq_low_limit,
	input  wire logic [15:0] freq_high_limit,
	input  wire logic        dc_undervolt,
	input  wire logic        dc_overvolt,
	input  wire logic        over_current_limit,
	input  wire logic [15:0] current_trip_delay,
	input  wire logic        motor_overtemp,
	input  wire logic        converter_overtemp,
	input  wire logic        thermistor_overtemp,
	input  wire logic        start_terminal,
	input  wire logic        term_reverse,
	input  wire logic [15:0] ref_min,
	input  wire logic [15:0] ref_max,
	// Drive-side commands.
	output logic      [1:0]  preset_select,
	output logic      [15:0] speed_setpoint,
	output logic             reverse_dir,
	output logic             output_enable,
	output logic             dc_brake_req,
	output logic             quick_stop_req,
	output logic             ramp_stop_req,
	output logic             freeze_req,
	output logic             run_permit,
	output logic             jog_select,
	output logic             trip_reset_pulse,
	output logic             trip_out,
	output logic             relay1_on,
	output logic             relay2_on,
	output logic      [1:0]  setup_select
);

	logic [15:0] cmd_r;
	logic [15:0] ref_r;
	logic [7:0]  cfg_r;
	logic        reset_bit_r;
	logic [15:0] ilim_cnt_r;
	logic        trip_r;
	logic [15:0] status_r;
	logic [15:0] freq_word_r;
	logic        serial_ok;
	logic        frozen;
	logic [15:0] ref_mag;
	logic [31:0] ref_prod;
	logic [31:0] freq_prod;
	logic [15:0] freq_span;
	logic [15:0] freq_off;
	logic [1:0]  pin_meta_r;
	logic [1:0]  pin_mid_r;
	logic [1:0]  pin_last_r;
	logic [1:0]  pin_clean_r;
	logic        start_term_ok;
	logic        term_rev_ok;
	logic        cmd_wr;
	logic        ref_wr;
	logic        cfg_wr;
	logic        reset_edge;

	// Two's complement negation, shared by the reference and frequency paths.
	function automatic logic [15:0] negate(input logic [15:0] v);
		return ~v + 16'h0001;
	endfunction

	// True when a register write strobe addresses the given word.
	function automatic logic wr_hit(input logic wr, input logic [3:0] addr,
		input logic [3:0] target);
		return wr && (addr == target);
	endfunction

	// Magnitude of a two's complement word; the most negative value saturates.
	function automatic logic [15:0] magnitude(input logic [15:0] v);
		logic [15:0] m;
		m = v[15] ? negate(v) : v;
		if (m[15]) begin
			m = 16'h7FFF;
		end
		return m;
	endfunction

	assign serial_ok = !panel_stop_key && !cfg_r[CFG_LOCAL]; // RULE_01

	// The terminals are asynchronous to mclk. Three stages settle them and the
	// clean level moves only when the second and third agree, so a one-cycle
	// glitch that slips past the first stage is never taken as a command.
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_meta_r <= 2'h0;
			pin_mid_r  <= 2'h0;
			pin_last_r <= 2'h0;
		end else begin
			pin_meta_r <= {term_reverse, start_terminal};
			pin_mid_r  <= pin_meta_r;
			pin_last_r <= pin_mid_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_clean_r <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (pin_mid_r[i] == pin_last_r[i]) begin
					pin_clean_r[i] <= pin_last_r[i];
				end
			end
		end
	end

	assign start_term_ok = pin_clean_r[0];
	assign term_rev_ok   = pin_clean_r[1];

	// A command word written without its valid bit is dropped like a telegram.
	assign cmd_wr = wr_hit(reg_wr, reg_addr, ADDR_CMD) && reg_wdata[CMD_VALID]; // RULE_21
	assign ref_wr = wr_hit(reg_wr, reg_addr, ADDR_REF);
	assign cfg_wr = wr_hit(reg_wr, reg_addr, ADDR_CONFIG);

	// A telegram's word and reference are latched as a pair, only when the link is allowed
	// to control and the word says its data is valid; register writes load either one alone.
	always_ff @(posedge mclk) begin
		if (rst) begin
			cmd_r <= CMD_RESET_VAL;
			ref_r <= REF_RESET_VAL;
		end else if (serial_ok) begin
			if (tel_valid && tel_cmd[CMD_VALID]) begin // RULE_21
				cmd_r <= tel_cmd; // RULE_25
				ref_r <= tel_ref; // RULE_07
			end else if (cmd_wr) begin
				cmd_r <= reg_wdata; // RULE_21
			end else if (ref_wr) begin
				ref_r <= reg_wdata;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_r <= CFG_RESET_VAL;
		end else if (cfg_wr) begin
			cfg_r <= reg_wdata[7:0];
		end
	end

	// Edge detection on the reset bit; a held level gives one pulse only.
	assign reset_edge = cmd_r[CMD_RESET] && !reset_bit_r; // RULE_18

	always_ff @(posedge mclk) begin
		if (rst) begin
			reset_bit_r      <= 1'b0;
			trip_reset_pulse <= 1'b0;
		end else begin
			reset_bit_r      <= cmd_r[CMD_RESET];
			trip_reset_pulse <= reset_edge; // RULE_18
		end
	end

	// Current limit trip timer; the trip holds until a reset edge.
	always_ff @(posedge mclk) begin
		if (rst) begin
			ilim_cnt_r <= 16'h0000;
			trip_r     <= 1'b0;
		end else begin
			if (!over_current_limit) begin
				ilim_cnt_r <= 16'h0000;
			end else if (ilim_cnt_r != 16'hFFFF) begin
				ilim_cnt_r <= ilim_cnt_r + 16'h0001;
			end
			if (over_current_limit && ilim_cnt_r >= current_trip_delay) begin
				trip_r <= 1'b1; // RULE_05
			end else if (reset_edge) begin
				trip_r <= 1'b0; // RULE_18
			end
		end
	end

	assign frozen = !cmd_r[CMD_FREEZE_N]; // RULE_15

	// Command decode registered so every drive-side output comes from a flop.
	always_ff @(posedge mclk) begin
		if (rst) begin
			preset_select <= 2'h0;
			jog_select    <= 1'b0;
			freeze_req    <= 1'b0;
		end else begin
			preset_select <= cmd_r[CMD_PRESET_HI:CMD_PRESET_LO]; // RULE_11
			jog_select    <= cmd_r[CMD_JOG]; // RULE_19
			freeze_req    <= frozen;
		end
	end

	// Stops and start permission. Freeze blocks ramp stop, quick stop and the
	// start terminal, never coast or brake, so a frozen drive stays stoppable.
	always_ff @(posedge mclk) begin
		if (rst) begin
			output_enable  <= 1'b0;
			dc_brake_req   <= 1'b0;
			quick_stop_req <= 1'b0;
			ramp_stop_req  <= 1'b0;
			run_permit     <= 1'b0;
		end else begin
			dc_brake_req   <= !cmd_r[CMD_DC_BRAKE_N]; // RULE_12
			output_enable  <= cmd_r[CMD_COAST_N] && !trip_r; // RULE_13
			quick_stop_req <= !cmd_r[CMD_QSTOP_N] && !frozen; // RULE_14
			ramp_stop_req  <= !frozen && !cmd_r[CMD_START]; // RULE_16
			run_permit     <= cmd_r[CMD_COAST_N] && !trip_r
				&& (frozen || (cmd_r[CMD_START] && start_term_ok)); // RULE_17
		end
	end

	// Relays and setup follow the word only while configured for bus control.
	always_ff @(posedge mclk) begin
		if (rst) begin
			relay1_on    <= 1'b0;
			relay2_on    <= 1'b0;
			setup_select <= 2'h0;
		end else begin
			relay1_on <= cfg_r[CFG_RELAY1_BUS] && cmd_r[CMD_RELAY1]; // RULE_22
			relay2_on <= cfg_r[CFG_RELAY2_BUS] && cmd_r[CMD_RELAY2]; // RULE_22
			if (cfg_r[CFG_MULTISETUP]) begin
				setup_select <= cmd_r[CMD_SETUP_HI:CMD_SETUP_LO]; // RULE_23
			end
		end
	end

	// Direction and trip. Bit 9 of the word is never looked at.
	always_ff @(posedge mclk) begin
		if (rst) begin
			reverse_dir <= 1'b0;
			trip_out    <= 1'b0;
		end else begin
			reverse_dir <= ref_r[15] ^ (cfg_r[CFG_REV_BUS] ? cmd_r[CMD_REVERSE]
				: term_rev_ok); // RULE_09 RULE_24 RULE_20
			trip_out    <= trip_r;
		end
	end

	// Reference scaling: 0..16384 maps onto ref_min..ref_max.
	always_comb begin
		ref_mag  = magnitude(ref_r);
		ref_prod = 32'(ref_mag) * 32'(ref_max - ref_min);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			speed_setpoint <= 16'h0000;
		end else begin
			speed_setpoint <= ref_min + ref_prod[SCALE_SHIFT +: 16]; // RULE_08
		end
	end

	// Output frequency scaled so the limit span equals 16384.
	always_comb begin
		freq_span = (freq_high_limit > freq_low_limit)
			? (freq_high_limit - freq_low_limit) : 16'h0001;
		freq_off  = (out_freq_hz > freq_low_limit) ? (out_freq_hz - freq_low_limit) : 16'h0000;
		freq_prod = (32'(freq_off) << SCALE_SHIFT) / 32'(freq_span);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			freq_word_r <= 16'h0000;
		end else if (freq_prod > 32'h0000_7FFF) begin
			// Above 7FFF, twice full range, the word clips at 7FFF, or at its negation 8001 when reversed.
			freq_word_r <= reverse_dir ? negate(16'h7FFF) : 16'h7FFF; // RULE_10
		end else begin
			freq_word_r <= reverse_dir ? negate(freq_prod[15:0])
				: freq_prod[15:0]; // RULE_10
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			status_r <= 16'h0000;
		end else begin
			status_r              <= 16'h0000;
			status_r[ST_SERIAL]   <= serial_ok; // RULE_01
			status_r[ST_IN_RANGE] <= (out_freq_hz > freq_low_limit)
				&& (out_freq_hz < freq_high_limit); // RULE_02
			status_r[ST_RUNNING]  <= cmd_r[CMD_START] || (out_freq_hz != 16'h0000); // RULE_03
			status_r[ST_VOLT]     <= dc_undervolt || dc_overvolt; // RULE_04
			status_r[ST_CURRENT]  <= over_current_limit; // RULE_05
			status_r[ST_THERMAL]  <= motor_overtemp || converter_overtemp
				|| thermistor_overtemp; // RULE_06
		end
	end

	// Register reads: data in the cycle after the strobe, zero otherwise.
	always_ff @(posedge mclk) begin
		if (rst || !reg_rd) begin
			reg_rdata <= 16'h0000;
		end else begin
			unique case (reg_addr)
				ADDR_STATUS:  reg_rdata <= status_r;
				ADDR_OUTFREQ: reg_rdata <= freq_word_r;
				ADDR_CONFIG:  reg_rdata <= {8'h00, cfg_r};
				ADDR_ACTIVE:  reg_rdata <= cmd_r;
				ADDR_TRIPCNT: reg_rdata <= ilim_cnt_r;
				ADDR_REF:     reg_rdata <= ref_r;
				default:      reg_rdata <= 16'h0000;
			endcase
		end
	end

endmodule // drive_control_status_words

// File: verif/drive_words_checker_sva.sv
// Port checks for the drive word interpreter, bound to its top module.
// Assumes one mclk domain and the one-cycle read timing of the register port.
`timescale 1ns/1ps

module drive_words_checker
	import drive_words_pkg::*;
(
	// Clock and reset.
	input wire logic        mclk,
	input wire logic        rst,
	// Register port.
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// Telegram and drive side.
	input wire logic        tel_valid,
	input wire logic [15:0] tel_cmd,
	input wire logic        panel_stop_key,
	input wire logic [15:0] out_freq_hz,
	input wire logic [15:0] freq_low_limit,
	input wire logic [15:0] freq_high_limit,
	input wire logic        dc_undervolt,
	input wire logic        dc_overvolt,
	input wire logic        over_current_limit,
	input wire logic        motor_overtemp,
	input wire logic        converter_overtemp,
	input wire logic        thermistor_overtemp,
	input wire logic        jog_select,
	input wire logic        relay1_on,
	input wire logic        trip_reset_pulse
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Status reads are judged only when inputs held still, so the capture lag cannot matter.
	logic st_rd;
	assign st_rd = reg_rd && reg_addr == ADDR_STATUS;

	a_serial_refused: assert property (st_rd && panel_stop_key && $past(panel_stop_key)
		|=> !reg_rdata[ST_SERIAL]) else $error("Serial bit set under panel stop.");
	a_range_strict: assert property (st_rd && $stable(out_freq_hz) |=>
		reg_rdata[ST_IN_RANGE] == ($past(out_freq_hz) > freq_low_limit
		&& $past(out_freq_hz) < freq_high_limit)) else $error("In-range bit wrong.");
	a_volt_warning: assert property (st_rd && $stable(dc_undervolt) && $stable(dc_overvolt)
		|=> reg_rdata[ST_VOLT] == ($past(dc_undervolt) || $past(dc_overvolt)))
		else $error("Voltage bit wrong.");
	a_current_bit: assert property (st_rd && $stable(over_current_limit)
		|=> reg_rdata[ST_CURRENT] == $past(over_current_limit)) else $error("Current bit wrong.");
	a_thermal_bit: assert property (st_rd && $stable(motor_overtemp) && $stable(converter_overtemp)
		&& $stable(thermistor_overtemp) |=> reg_rdata[ST_THERMAL] == ($past(motor_overtemp)
		|| $past(converter_overtemp) || $past(thermistor_overtemp))) else $error("Thermal bit wrong.");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("Read data outside read cycle.");
	a_invalid_ignored: assert property (tel_valid && !tel_cmd[CMD_VALID] && !reg_wr ##1
		!tel_valid && !reg_wr |=> $stable(jog_select) && $stable(relay1_on))
		else $error("Invalid telegram changed outputs.");
	a_pulse_single: assert property (trip_reset_pulse |=> !trip_reset_pulse)
		else $error("Trip reset pulse longer than one cycle.");

	c_panel_read: cover property (st_rd && panel_stop_key);
	c_trip_reset: cover property (trip_reset_pulse);
	c_invalid_tel: cover property (tel_valid && !tel_cmd[CMD_VALID]);
endmodule // drive_words_checker

bind drive_control_status_words drive_words_checker i_drive_words_checker (.mclk, .rst,
	.reg_addr, .reg_wr, .reg_rd, .reg_rdata, .tel_valid, .tel_cmd, .panel_stop_key,
	.out_freq_hz, .freq_low_limit, .freq_high_limit, .dc_undervolt, .dc_overvolt,
	.over_current_limit, .motor_overtemp, .converter_overtemp, .thermistor_overtemp,
	.jog_select, .relay1_on, .trip_reset_pulse);

// File: verif/fieldbus_master.sv
// Model of the bus master that hands telegrams to the drive.
// Assumes the framer shows each telegram as a one-cycle word pair on mclk.
`timescale 1ns/1ps

module fieldbus_master (
	// Clock.
	input  wire logic        mclk,
	// Telegram words.
	output logic             tel_valid,
	output logic      [15:0] tel_cmd,
	output logic      [15:0] tel_ref
);
	initial begin
		tel_valid = 1'b0;
		tel_cmd   = 16'h0000;
		tel_ref   = 16'h0000;
	end

	// Words are scrambled after the valid cycle so stale data is never mistaken for a telegram.
	task automatic send(input logic [15:0] cmd, input logic [15:0] mag, input logic neg);
		@(posedge mclk);
		tel_valid <= 1'b1;
		tel_cmd   <= cmd;
		tel_ref   <= neg ? ~mag + 16'h0001 : mag;
		@(posedge mclk);
		tel_valid <= 1'b0;
		tel_cmd   <= ~cmd;
		tel_ref   <= ~mag;
	endtask
endmodule // fieldbus_master

// File: verif/tb_top.sv
// Self-checking bench for the drive command and status word interpreter.
// Assumes the bus master model supplies telegrams and the checker is bound.
`timescale 1ns/1ps

module tb_top import drive_words_pkg::*; ;
	logic        mclk, rst, reg_wr, reg_rd, tel_valid, panel_stop_key, start_terminal;
	logic        term_reverse, dc_undervolt, dc_overvolt, over_current_limit;
	logic        motor_overtemp, converter_overtemp, thermistor_overtemp, reverse_dir;
	logic        output_enable, dc_brake_req, quick_stop_req, ramp_stop_req, freeze_req;
	logic        run_permit, jog_select, trip_reset_pulse, trip_out, relay1_on, relay2_on;
	logic [1:0]  preset_select, setup_select;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, tel_cmd, tel_ref, out_freq_hz, speed_setpoint, outs;
	int          bad_count = 0, checked = 0, pulses = 0, p;
	typedef struct { logic [15:0] c; logic [15:0] m; logic [15:0] e; } cmd_case_s;
	cmd_case_s cases [0:13] = '{
		'{16'h047C, 16'h6000, 16'h0000}, '{16'h047D, 16'h6000, 16'h2000},
		'{16'h047E, 16'h6000, 16'h4000}, '{16'h047F, 16'h67F8, 16'h6210},
		'{16'h047B, 16'h0100, 16'h0100}, '{16'h0477, 16'h0200, 16'h0000},
		'{16'h046F, 16'h0080, 16'h0080}, '{16'h043F, 16'h0050, 16'h0040},
		'{16'h045F, 16'h0020, 16'h0020}, '{16'h041F, 16'h0070, 16'h0030},
		'{16'h057F, 16'h0008, 16'h0008}, '{16'h067F, 16'h67F8, 16'h6210},
		'{16'h007B, 16'h0100, 16'h0000}, '{16'h7C7F, 16'h1803, 16'h1803}};

	assign outs = {1'b0, preset_select, setup_select, reverse_dir, output_enable, dc_brake_req,
		quick_stop_req, ramp_stop_req, freeze_req, run_permit, jog_select, trip_out, relay1_on,
		relay2_on};

	drive_control_status_words i_drive_control_status_words (.mclk, .rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tel_valid, .tel_cmd, .tel_ref,
		.panel_stop_key, .out_freq_hz, .freq_low_limit(16'h0000), .freq_high_limit(16'h0032),
		.dc_undervolt, .dc_overvolt, .over_current_limit, .current_trip_delay(16'h0008),
		.motor_overtemp, .converter_overtemp, .thermistor_overtemp, .start_terminal,
		.term_reverse, .ref_min(16'h1000), .ref_max(16'h3000), .preset_select, .speed_setpoint,
		.reverse_dir, .output_enable, .dc_brake_req, .quick_stop_req, .ramp_stop_req,
		.freeze_req, .run_permit, .jog_select, .trip_reset_pulse, .trip_out, .relay1_on,
		.relay2_on, .setup_select);
	fieldbus_master i_fieldbus_master (.mclk, .tel_valid, .tel_cmd, .tel_ref);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) if (trip_reset_pulse === 1'b1) pulses++;

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input string n, input logic [3:0] a, input logic [15:0] e);
		repeat (2) @(posedge mclk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(n, e, reg_rdata);
	endtask
	// Decoded outputs settle two edges after the telegram, so three edges leave margin.
	task automatic tel(input logic [15:0] c, input logic [15:0] m, input logic neg);
		i_fieldbus_master.send(c, m, neg);
		repeat (3) @(posedge mclk);
		#1;
	endtask

	initial begin
		repeat (100000) @(posedge mclk);
		bad_count++;
		end_of_test;
	end

	initial begin
		{rst, start_terminal, reg_wr, reg_rd, panel_stop_key, term_reverse} = 6'h30;
		{dc_undervolt, dc_overvolt, over_current_limit, motor_overtemp} = 4'h0;
		{converter_overtemp, thermistor_overtemp, reg_addr, reg_wdata} = 22'h000000;
		out_freq_hz = 16'h0019;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		wr(ADDR_CONFIG, 16'h000E);
		foreach (cases[i]) begin
			tel(cases[i].c, 16'h2000, 1'b0);
			chk("decoded outputs", cases[i].e, outs & cases[i].m);
		end
		wr(ADDR_CONFIG, 16'h0000);
		tel(16'h047F, 16'h2000, 1'b0);
		chk("relays and setup", 16'h1800, outs & 16'h1803);
		for (int i = 0; i < 3; i++) begin
			tel(16'h047F, 16'(i) << 13, 1'b0);
			chk("speed setpoint", 16'h1000 + (16'(i) << 12), speed_setpoint);
		end
		tel(16'h047F, 16'h2000, 1'b1);
		chk("reverse", 16'h2001, {speed_setpoint[15:1], reverse_dir});
		term_reverse <= 1'b1;
		tel(16'h047F, 16'h2000, 1'b1);
		chk("reverse", 16'h0000, 16'(reverse_dir));
		wr(ADDR_CONFIG, 16'h0010);
		tel(16'h847F, 16'h2000, 1'b0);
		chk("reverse", 16'h0001, 16'(reverse_dir));
		tel(16'h047F, 16'h2000, 1'b0);
		rd_chk("status", ADDR_STATUS, 16'h0E00);
		rd_chk("out freq", ADDR_OUTFREQ, 16'h2000);
		rd_chk("unmapped", 4'hF, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			{dc_undervolt, dc_overvolt, over_current_limit, motor_overtemp, converter_overtemp,
				thermistor_overtemp} <= 6'h01 << i;
			rd_chk("status flag", ADDR_STATUS,
				i < 3 ? 16'h8E00 : i == 3 ? 16'h4E00 : 16'h2E00);
		end
		dc_undervolt <= 1'b0;
		over_current_limit <= 1'b1;
		for (int k = 0; k < 40 && trip_out !== 1'b1; k++) begin
			@(posedge mclk);
			#1;
		end
		chk("trip", 16'h0001, 16'(trip_out));
		over_current_limit <= 1'b0;
		p = pulses;
		tel(16'h04FF, 16'h2000, 1'b0);
		tel(16'h04FF, 16'h2000, 1'b0);
		chk("reset pulses", 16'h0001, 16'(pulses - p));
		chk("trip", 16'h0000, 16'(trip_out));
		panel_stop_key <= 1'b1;
		tel(16'h057F, 16'h2000, 1'b0);
		chk("jog", 16'h0000, 16'(jog_select));
		rd_chk("status", ADDR_STATUS, 16'h0C00);
		panel_stop_key <= 1'b0;
		out_freq_hz <= 16'h0032;
		rd_chk("status", ADDR_STATUS, 16'h0A00);
		out_freq_hz <= 16'h0000;
		tel(16'h043F, 16'h2000, 1'b0);
		rd_chk("status", ADDR_STATUS, 16'h0200);
		wr(ADDR_CMD, 16'h017F);
		wr(ADDR_REF, 16'h4000);
		repeat (2) @(posedge mclk);
		#1 chk("jog", 16'h0000, 16'(jog_select));
		chk("speed setpoint", 16'h3000, speed_setpoint);
		wr(ADDR_CMD, 16'h057F);
		rd_chk("active word", ADDR_ACTIVE, 16'h057F);
		rd_chk("reference", ADDR_REF, 16'h4000);
		rd_chk("config", ADDR_CONFIG, 16'h0010);
		rd_chk("trip count", ADDR_TRIPCNT, 16'h0000);
		end_of_test;
	end
endmodule // tb_top
